// >>> rtl/clock_mode_ctrl.sv
`timescale 1ns/10ps
`include "clock_mode_defines.svh"
module clock_mode_ctrl (
    input  wire logic                    core_clk,
    input  wire logic                    rst_b,
    input  wire logic [7:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [7:0]                   reg_rdata,
    input  wire logic                    wait_instr,
    input  wire logic                    wake_irq,
    input  wire logic                    main_osc_input,
    output clock_mode_pkg::clk_src_t     cpu_clk_src,
    output logic                         cpu_clk_en,
    output logic                         cpu_sleep,
    output logic                         periph_clk_off,
    output logic                         main_osc_run,
    output logic                         sub_osc_run,
    output logic                         onchip_osc_run,
    output logic                         pll_run,
    output logic                         osc_fail_irq,
    output logic                         osc_fail_reset
);
    logic [7:0]                  cz_reg;
    logic [7:0]                  cz_next;
    logic [7:0]                  c1_reg;
    logic [7:0]                  c1_next;
    logic [7:0]                  mon_reg;
    logic [7:0]                  mon_next;
    logic [7:0]                  pll_reg;
    logic [7:0]                  pll_next;
    logic                        lock_reg;
    logic                        unlock_reg;
    logic [3:0]                  div_cnt_reg;
    logic [3:0]                  div_last;
    logic                        irq_reg;
    clock_mode_pkg::sleep_state_t sleep_reg;
    clock_mode_pkg::sleep_state_t sleep_next;
    clock_mode_pkg::clk_mode_t   mode;
    clock_mode_pkg::clk_src_t    src_reg;
    logic                        wr_cz;
    logic                        wr_c1;
    logic                        wr_mon;
    logic                        wr_pll;
    logic                        halt;
    logic                        stop_exit;
    osc_mon_if                   mon_if ();

    osc_stop_monitor u_monitor (
        .core_clk       (core_clk),
        .rst_b          (rst_b),
        .main_osc_input (main_osc_input),
        .mon            (mon_if.mon)
    );

    assign mon_if.enable = mon_reg[`BIT_OSC_MON_ENABLE];
    assign wr_cz  = reg_wr && (reg_addr == `ADDR_CLOCK_CTRL_ZERO);
    assign wr_c1  = reg_wr && (reg_addr == `ADDR_CLOCK_CTRL_ONE);
    assign wr_mon = reg_wr && (reg_addr == `ADDR_OSC_MONITOR_CTRL);
    assign wr_pll = reg_wr && (reg_addr == `ADDR_PLL_CONTROL);
    assign halt   = (sleep_reg == clock_mode_pkg::OSC_HALT);
    assign stop_exit = (sleep_reg == clock_mode_pkg::SLEEP_STOP) && wake_irq;

    // Operating mode from the selection bits
    always_comb
    begin
        if (cz_reg[`BIT_SUB_CPU_SELECT])
            mode = cz_reg[`BIT_MAIN_OSC_STOP] ? clock_mode_pkg::LOW_POWER : clock_mode_pkg::LOW_SPEED;
        else if (mon_reg[`BIT_ONCHIP_SELECT])
            mode = cz_reg[`BIT_MAIN_OSC_STOP] ? clock_mode_pkg::ONCHIP_LP : clock_mode_pkg::ONCHIP;
        else if (c1_reg[`BIT_PLL_CPU_SELECT] && pll_reg[`BIT_PLL_ENABLE_SELECT])
            mode = clock_mode_pkg::PLL_MODE;
        else
            mode = clock_mode_pkg::HIGH_MID;
    end

    // Accepted write values; refused fields keep their old value
    always_comb
    begin
        cz_next = cz_reg;
        if (wr_cz)
        begin
            cz_next[3:0] = {reg_wdata[3], cz_reg[2], reg_wdata[1:0]};
            cz_next[`BIT_DIV8_SELECT] = reg_wdata[`BIT_DIV8_SELECT];
            if (!lock_reg)
                cz_next[`BIT_PERIPH_OFF_WAIT] = reg_wdata[`BIT_PERIPH_OFF_WAIT];
            if (!(cz_reg[`BIT_SUB_CPU_SELECT] && !reg_wdata[`BIT_SUB_OSC_ENABLE]))
                cz_next[`BIT_SUB_OSC_ENABLE] = reg_wdata[`BIT_SUB_OSC_ENABLE];
            if (!lock_reg && reg_wdata[`BIT_MAIN_OSC_STOP] != cz_reg[`BIT_MAIN_OSC_STOP])
            begin
                if (reg_wdata[`BIT_MAIN_OSC_STOP] &&
                    (mode == clock_mode_pkg::LOW_SPEED || mode == clock_mode_pkg::ONCHIP))
                begin
                    cz_next[`BIT_MAIN_OSC_STOP] = 1'b1;
                    cz_next[`BIT_DIV8_SELECT]   = 1'b1;
                end
                else if (!reg_wdata[`BIT_MAIN_OSC_STOP] &&
                         (mode == clock_mode_pkg::LOW_POWER || mode == clock_mode_pkg::ONCHIP_LP))
                    cz_next[`BIT_MAIN_OSC_STOP] = 1'b0;
            end
            if (!lock_reg && reg_wdata[`BIT_SUB_CPU_SELECT] && mode == clock_mode_pkg::HIGH_MID &&
                cz_reg[`BIT_SUB_OSC_ENABLE])
                cz_next[`BIT_SUB_CPU_SELECT] = 1'b1;
            else if (!lock_reg && !reg_wdata[`BIT_SUB_CPU_SELECT] && mode == clock_mode_pkg::LOW_SPEED)
                cz_next[`BIT_SUB_CPU_SELECT] = 1'b0;
        end
        if (stop_exit)
            cz_next[`BIT_DIV8_SELECT] = 1'b1;
    end

    always_comb
    begin
        c1_next = c1_reg;
        if (wr_c1)
        begin
            c1_next[5:2] = reg_wdata[5:2];
            c1_next[`BIT_CPU_DIV_HIGH:`BIT_CPU_DIV_LOW] = reg_wdata[`BIT_CPU_DIV_HIGH:`BIT_CPU_DIV_LOW];
            if (!lock_reg && reg_wdata[`BIT_STOP_MODE_REQ] && mode != clock_mode_pkg::PLL_MODE)
                c1_next[`BIT_STOP_MODE_REQ] = 1'b1;
            if (!lock_reg && reg_wdata[`BIT_PLL_CPU_SELECT] && mode == clock_mode_pkg::HIGH_MID &&
                pll_reg[`BIT_PLL_ENABLE_SELECT])
                c1_next[`BIT_PLL_CPU_SELECT] = 1'b1;
            else if (!lock_reg && !reg_wdata[`BIT_PLL_CPU_SELECT])
                c1_next[`BIT_PLL_CPU_SELECT] = 1'b0;
        end
        if (stop_exit)
            c1_next[`BIT_STOP_MODE_REQ] = 1'b0;
    end

    always_comb
    begin
        mon_next = mon_reg;
        if (wr_mon)
        begin
            mon_next[6:4] = reg_wdata[6:4];
            mon_next[`BIT_FAIL_RESP_SELECT] = reg_wdata[`BIT_FAIL_RESP_SELECT];
            if (!lock_reg)
                mon_next[`BIT_OSC_MON_ENABLE] = reg_wdata[`BIT_OSC_MON_ENABLE];
            if (reg_wdata[`BIT_ONCHIP_SELECT] && mode == clock_mode_pkg::HIGH_MID)
                mon_next[`BIT_ONCHIP_SELECT] = 1'b1;
            else if (!reg_wdata[`BIT_ONCHIP_SELECT] && mode == clock_mode_pkg::ONCHIP)
                mon_next[`BIT_ONCHIP_SELECT] = 1'b0;
            if (!reg_wdata[`BIT_OSC_FAIL_FLAG])
                mon_next[`BIT_OSC_FAIL_FLAG] = 1'b0;
        end
        if (mon_if.stop_evt || mon_if.restart_evt)
            mon_next[`BIT_OSC_FAIL_FLAG] = 1'b1;
        mon_next[`BIT_MAIN_STOPPED] = mon_if.main_stopped;
    end

    always_comb
    begin
        pll_next = pll_reg;
        if (wr_pll && !lock_reg && !(c1_reg[`BIT_PLL_CPU_SELECT] && !reg_wdata[`BIT_PLL_ENABLE_SELECT]))
            pll_next = reg_wdata;
    end

    // Control registers; a reset-response halt reinitialises them
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cz_reg  <= `RST_CLOCK_CTRL_ZERO;
            c1_reg  <= `RST_CLOCK_CTRL_ONE;
            mon_reg <= `RST_OSC_MONITOR_CTRL;
            pll_reg <= `RST_PLL_CONTROL;
        end
        else if (halt)
        begin
            cz_reg  <= `RST_CLOCK_CTRL_ZERO;
            c1_reg  <= `RST_CLOCK_CTRL_ONE;
            mon_reg <= `RST_OSC_MONITOR_CTRL;
            pll_reg <= `RST_PLL_CONTROL;
        end
        else
        begin
            cz_reg  <= cz_next;
            c1_reg  <= c1_next;
            mon_reg <= mon_next;
            pll_reg <= pll_next;
        end
    end

    // Lock bit writable only while unlocked
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lock_reg   <= 1'b0;
            unlock_reg <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == `ADDR_WRITE_PROTECT)
                unlock_reg <= reg_wdata[`BIT_MODE_UNLOCK];
            if (reg_wr && reg_addr == `ADDR_PROC_MODE_TWO && unlock_reg)
                lock_reg <= reg_wdata[`BIT_CLOCK_LOCK];
        end
    end

    // Sleep and halt sequencing
    always_comb
    begin
        sleep_next = sleep_reg;
        case (sleep_reg)
            clock_mode_pkg::RUN_NORMAL:
            begin
                if (c1_next[`BIT_STOP_MODE_REQ] && !c1_reg[`BIT_STOP_MODE_REQ])
                    sleep_next = clock_mode_pkg::SLEEP_STOP;
                else if (wait_instr && mode != clock_mode_pkg::PLL_MODE)
                    sleep_next = clock_mode_pkg::SLEEP_WAIT;
            end
            clock_mode_pkg::SLEEP_STOP,
            clock_mode_pkg::SLEEP_WAIT:
            begin
                if (wake_irq)
                    sleep_next = clock_mode_pkg::RUN_NORMAL;
            end
            clock_mode_pkg::OSC_HALT:
                sleep_next = clock_mode_pkg::OSC_HALT;
            default:
                sleep_next = clock_mode_pkg::RUN_NORMAL;
        endcase
        if (mon_if.stop_evt && !mon_reg[`BIT_FAIL_RESP_SELECT] && !mon_reg[`BIT_OSC_FAIL_FLAG])
            sleep_next = clock_mode_pkg::OSC_HALT;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            sleep_reg <= clock_mode_pkg::RUN_NORMAL;
        else
            sleep_reg <= sleep_next;
    end

    // Interrupt request on detection with interrupt response
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_reg <= 1'b0;
        else
            irq_reg <= (mon_if.stop_evt || mon_if.restart_evt) && mon_reg[`BIT_FAIL_RESP_SELECT] &&
                       !mon_reg[`BIT_OSC_FAIL_FLAG];
    end

    // CPU source; after stop the divide-by-8 path applies for every source, sub included
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            src_reg <= clock_mode_pkg::SRC_MAIN;
        else if (cz_reg[`BIT_SUB_CPU_SELECT])
            src_reg <= clock_mode_pkg::SRC_SUB;
        else if (mon_reg[`BIT_ONCHIP_SELECT])
            src_reg <= clock_mode_pkg::SRC_ONCHIP;
        else if (mode == clock_mode_pkg::PLL_MODE)
            src_reg <= clock_mode_pkg::SRC_PLL;
        else
            src_reg <= clock_mode_pkg::SRC_MAIN;
    end

    // Divider: one enable pulse every N cycles
    always_comb
    begin
        if (cz_reg[`BIT_DIV8_SELECT])
            div_last = 4'h7;
        else
            case (c1_reg[`BIT_CPU_DIV_HIGH:`BIT_CPU_DIV_LOW])
                `CPU_DIV_NONE: div_last = 4'h0;
                `CPU_DIV_2:    div_last = 4'h1;
                `CPU_DIV_4:    div_last = 4'h3;
                `CPU_DIV_16:   div_last = 4'hF;
                default:       div_last = 4'h0;
            endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_cnt_reg <= 4'h0;
            cpu_clk_en  <= 1'b0;
        end
        else if (sleep_reg != clock_mode_pkg::RUN_NORMAL)
        begin
            div_cnt_reg <= 4'h0;
            cpu_clk_en  <= 1'b0;
        end
        else
        begin
            cpu_clk_en  <= (div_cnt_reg == 4'h0);
            div_cnt_reg <= (div_cnt_reg >= div_last) ? 4'h0 : div_cnt_reg + 4'h1;
        end
    end

    // Register read, data one cycle later
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            case (reg_addr)
                `ADDR_CLOCK_CTRL_ZERO:  reg_rdata <= cz_reg;
                `ADDR_CLOCK_CTRL_ONE:   reg_rdata <= c1_reg;
                `ADDR_OSC_MONITOR_CTRL: reg_rdata <= mon_reg;
                `ADDR_PLL_CONTROL:      reg_rdata <= pll_reg;
                `ADDR_PROC_MODE_TWO:    reg_rdata <= {6'h00, lock_reg, 1'b0};
                `ADDR_WRITE_PROTECT:    reg_rdata <= {6'h00, unlock_reg, 1'b0};
                `ADDR_MODE_STATUS:      reg_rdata <= {1'b0, sleep_reg, mode, src_reg};
                default:                reg_rdata <= 8'h00;
            endcase
    end

    assign cpu_clk_src    = src_reg;
    assign cpu_sleep      = (sleep_reg != clock_mode_pkg::RUN_NORMAL);
    assign periph_clk_off = (sleep_reg == clock_mode_pkg::SLEEP_WAIT) && cz_reg[`BIT_PERIPH_OFF_WAIT];
    assign main_osc_run   = !cz_reg[`BIT_MAIN_OSC_STOP] && (sleep_reg != clock_mode_pkg::SLEEP_STOP);
    assign sub_osc_run    = cz_reg[`BIT_SUB_OSC_ENABLE];
    assign onchip_osc_run = mon_reg[`BIT_ONCHIP_SELECT] || mon_reg[`BIT_OSC_MON_ENABLE];
    assign pll_run        = pll_reg[`BIT_PLL_ENABLE_SELECT];
    assign osc_fail_irq   = irq_reg;
    assign osc_fail_reset = halt;

    sequence stop_then_wake;
        (sleep_reg == clock_mode_pkg::SLEEP_STOP) ##1 (sleep_reg == clock_mode_pkg::RUN_NORMAL);
    endsequence

    AST_PLL_FROM_HIGH: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(c1_reg[`BIT_PLL_CPU_SELECT]) |-> $past(mode) == clock_mode_pkg::HIGH_MID)
        else $error("PLL mode entered from wrong mode");
    AST_STOP_EXIT_DIV8: assert property (@(posedge core_clk) disable iff (!rst_b)
        stop_then_wake |-> cz_reg[`BIT_DIV8_SELECT])
        else $error("Divide by 8 not forced on stop exit");
    AST_MAIN_STOP_DIV8: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(cz_reg[`BIT_MAIN_OSC_STOP]) |-> cz_reg[`BIT_DIV8_SELECT] && !main_osc_run)
        else $error("Main stop without divide by 8");
    AST_LOW_SPEED_SUB: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(cz_reg[`BIT_SUB_CPU_SELECT]) |-> $past(cz_reg[`BIT_SUB_OSC_ENABLE]) ##1
        cpu_clk_src == clock_mode_pkg::SRC_SUB)
        else $error("Low speed entered without sub clock");
    AST_LOCK_IGNORES: assert property (@(posedge core_clk) disable iff (!rst_b)
        lock_reg && !halt && wr_c1 |=> $stable(c1_reg[1:0]))
        else $error("Locked bit changed");
    AST_NO_STOP_IN_PLL: assert property (@(posedge core_clk) disable iff (!rst_b)
        mode == clock_mode_pkg::PLL_MODE && sleep_reg == clock_mode_pkg::RUN_NORMAL |=>
        sleep_reg != clock_mode_pkg::SLEEP_STOP && sleep_reg != clock_mode_pkg::SLEEP_WAIT)
        else $error("Sleep entered from PLL mode");
    AST_MON_QUIET: assert property (@(posedge core_clk) disable iff (!rst_b)
        !mon_reg[`BIT_OSC_MON_ENABLE] ##1 !mon_reg[`BIT_OSC_MON_ENABLE] |=> !irq_reg && !$rose(halt))
        else $error("Detection while monitor disabled");
    AST_IRQ_RESPONSE: assert property (@(posedge core_clk) disable iff (!rst_b)
        mon_if.stop_evt && mon_reg[`BIT_FAIL_RESP_SELECT] && !mon_reg[`BIT_OSC_FAIL_FLAG] && !halt |=>
        irq_reg && !halt)
        else $error("Interrupt response missing");
    AST_HALT_STICKS: assert property (@(posedge core_clk) disable iff (!rst_b)
        mon_if.stop_evt && !mon_reg[`BIT_FAIL_RESP_SELECT] && !mon_reg[`BIT_OSC_FAIL_FLAG] |=>
        osc_fail_reset [*8])
        else $error("Reset response did not halt");
    AST_DIV_NONE: assert property (@(posedge core_clk) disable iff (!rst_b)
        (div_last == 4'h0 && sleep_reg == clock_mode_pkg::RUN_NORMAL) [*2] |=> cpu_clk_en)
        else $error("Undivided clock enable missing");
endmodule // clock_mode_ctrl

// >>> rtl/clock_mode_defines.svh
`ifndef CLOCK_MODE_DEFINES_SVH
`define CLOCK_MODE_DEFINES_SVH
`define ADDR_CLOCK_CTRL_ZERO   8'h00
`define ADDR_CLOCK_CTRL_ONE    8'h04
`define ADDR_OSC_MONITOR_CTRL  8'h08
`define ADDR_PLL_CONTROL       8'h0C
`define ADDR_PROC_MODE_TWO     8'h10
`define ADDR_WRITE_PROTECT     8'h14
`define ADDR_MODE_STATUS       8'h18
`define BIT_PERIPH_OFF_WAIT    2
`define BIT_SUB_OSC_ENABLE     4
`define BIT_MAIN_OSC_STOP      5
`define BIT_DIV8_SELECT        6
`define BIT_SUB_CPU_SELECT     7
`define BIT_STOP_MODE_REQ      0
`define BIT_PLL_CPU_SELECT     1
`define BIT_CPU_DIV_LOW        6
`define BIT_CPU_DIV_HIGH       7
`define BIT_OSC_MON_ENABLE     0
`define BIT_ONCHIP_SELECT      1
`define BIT_OSC_FAIL_FLAG      2
`define BIT_MAIN_STOPPED       3
`define BIT_FAIL_RESP_SELECT   7
`define BIT_PLL_ENABLE_SELECT  7
`define BIT_CLOCK_LOCK         1
`define BIT_MODE_UNLOCK        1
`define RST_CLOCK_CTRL_ZERO    8'h48
`define RST_CLOCK_CTRL_ONE     8'h00
`define RST_OSC_MONITOR_CTRL   8'h00
`define RST_PLL_CONTROL        8'h00
`define CPU_DIV_NONE           2'h0
`define CPU_DIV_2              2'h1
`define CPU_DIV_4              2'h2
`define CPU_DIV_16             2'h3
`define CORE_CLK_MHZ           125
`define OSC_TIMEOUT_NS         1000
`define OSC_TIMEOUT_CYC        ((`OSC_TIMEOUT_NS * `CORE_CLK_MHZ) / 1000)
`endif

// >>> rtl/clock_mode_pkg.sv
package clock_mode_pkg;
    typedef enum logic [2:0] {HIGH_MID, LOW_SPEED, LOW_POWER, PLL_MODE, ONCHIP, ONCHIP_LP} clk_mode_t;
    typedef enum logic [1:0] {RUN_NORMAL, SLEEP_STOP, SLEEP_WAIT, OSC_HALT} sleep_state_t;
    typedef enum logic [1:0] {SRC_MAIN, SRC_PLL, SRC_SUB, SRC_ONCHIP} clk_src_t;
endpackage

// >>> rtl/osc_mon_if.sv
`timescale 1ns/10ps
interface osc_mon_if;
    logic enable;
    logic stop_evt;
    logic restart_evt;
    logic main_stopped;
    modport mon (input enable, output stop_evt, output restart_evt, output main_stopped);
    modport ctl (output enable, input stop_evt, input restart_evt, input main_stopped);
endinterface

// >>> rtl/osc_stop_monitor.sv
`timescale 1ns/10ps
`include "clock_mode_defines.svh"
module osc_stop_monitor (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic main_osc_input,
    osc_mon_if.mon    mon
);
    logic       sync1_reg;
    logic       sync2_reg;
    logic       sync3_reg;
    logic [7:0] idle_reg;
    logic       stopped_reg;
    logic       stop_evt_reg;
    logic       restart_evt_reg;
    logic       edge_seen;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= main_osc_input;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign edge_seen = sync2_reg ^ sync3_reg;

    // Oscillator judged stopped after a full timeout with no edge
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            idle_reg    <= 8'h00;
            stopped_reg <= 1'b0;
        end
        else if (edge_seen)
        begin
            idle_reg    <= 8'h00;
            stopped_reg <= 1'b0;
        end
        else if (idle_reg == 8'(`OSC_TIMEOUT_CYC - 1))
            stopped_reg <= 1'b1;
        else
            idle_reg <= idle_reg + 8'h01;
    end

    // Events only while enabled
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stop_evt_reg    <= 1'b0;
            restart_evt_reg <= 1'b0;
        end
        else
        begin
            stop_evt_reg    <= mon.enable && !stopped_reg && (idle_reg == 8'(`OSC_TIMEOUT_CYC - 1)) && !edge_seen;
            restart_evt_reg <= mon.enable && stopped_reg && edge_seen;
        end
    end

    assign mon.stop_evt     = stop_evt_reg;
    assign mon.restart_evt  = restart_evt_reg;
    assign mon.main_stopped = stopped_reg;
endmodule // osc_stop_monitor

// >>> sim/clock_mode_ctrl_bench.sv
`timescale 1ns/10ps
`include "clock_mode_defines.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("Error %s exp %0h got %0h", nm, exp, got); end end
module clock_mode_ctrl_bench;
    logic core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, wait_instr = 0, wake_irq = 0;
    logic main_osc_input = 0, osc_on = 1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic cpu_clk_en, cpu_sleep, periph_clk_off, main_osc_run, sub_osc_run, osc_fail_irq, osc_fail_reset;
    logic onchip_osc_run, pll_run;
    clock_mode_pkg::clk_src_t cpu_clk_src;
    int error_cnt = 0, check_count = 0, cyc = 0, c;
    clock_mode_ctrl dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wait_instr(wait_instr), .wake_irq(wake_irq),
        .main_osc_input(main_osc_input), .cpu_clk_src(cpu_clk_src), .cpu_clk_en(cpu_clk_en),
        .cpu_sleep(cpu_sleep), .periph_clk_off(periph_clk_off), .main_osc_run(main_osc_run),
        .sub_osc_run(sub_osc_run), .onchip_osc_run(onchip_osc_run), .pll_run(pll_run),
        .osc_fail_irq(osc_fail_irq), .osc_fail_reset(osc_fail_reset));
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) if (osc_on) main_osc_input <= ~main_osc_input;
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            give_verdict();
        end
    end
    task give_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task do_reset();
        rst_b = 0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
        @(posedge core_clk);
        reg_wr <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a; reg_rd <= 1;
        @(posedge core_clk);
        reg_rd <= 0;
        @(negedge core_clk);
        `CHK("rdata", e, reg_rdata)
    endtask
    task per(input int n);
        // Let the divider settle on the new ratio before measuring
        repeat (17) @(negedge core_clk);
        c = 0;
        while (cpu_clk_en !== 1'b1 && c < 40) begin @(negedge core_clk); c++; end
        c = 0;
        do begin @(negedge core_clk); c++; end while (cpu_clk_en !== 1'b1 && c < 40);
        `CHK("div period", n, c)
    endtask
    task pulse_in(input int w);
        @(posedge core_clk);
        if (w) wait_instr <= 1; else wake_irq <= 1;
        @(posedge core_clk);
        wait_instr <= 0; wake_irq <= 0;
        repeat (2) @(negedge core_clk);
    endtask
    initial
    begin
        do_reset();
        rd(`ADDR_CLOCK_CTRL_ZERO, 8'h48);
        rd(`ADDR_CLOCK_CTRL_ONE, 8'h00);
        wr(`ADDR_CLOCK_CTRL_ZERO, 8'h08);
        wr(`ADDR_CLOCK_CTRL_ONE, 8'h00); per(1);
        wr(`ADDR_CLOCK_CTRL_ONE, 8'h40); per(2);
        wr(`ADDR_CLOCK_CTRL_ONE, 8'h80); per(4);
        wr(`ADDR_CLOCK_CTRL_ONE, 8'hC0); per(16);
        wr(`ADDR_CLOCK_CTRL_ZERO, 8'h48); per(8);
        wr(`ADDR_CLOCK_CTRL_ONE, 8'h00);
        wr(`ADDR_PLL_CONTROL, 8'h80);
        wr(`ADDR_CLOCK_CTRL_ONE, 8'h02); repeat (2) @(negedge core_clk);
        `CHK("src", clock_mode_pkg::SRC_PLL, cpu_clk_src)
        `CHK("pll run", 1'b1, pll_run)
        wr(`ADDR_CLOCK_CTRL_ONE, 8'h03); repeat (2) @(negedge core_clk);
        `CHK("sleep", 1'b0, cpu_sleep)
        pulse_in(1);
        `CHK("sleep", 1'b0, cpu_sleep)
        wr(`ADDR_CLOCK_CTRL_ONE, 8'h00);
        wr(`ADDR_CLOCK_CTRL_ZERO, 8'hC8); rd(`ADDR_CLOCK_CTRL_ZERO, 8'h48);
        wr(`ADDR_CLOCK_CTRL_ZERO, 8'h58); rd(`ADDR_CLOCK_CTRL_ONE, 8'h00);
        `CHK("sub run", 1'b1, sub_osc_run)
        wr(`ADDR_CLOCK_CTRL_ZERO, 8'hD8); repeat (2) @(negedge core_clk);
        `CHK("src", clock_mode_pkg::SRC_SUB, cpu_clk_src)
        wr(`ADDR_CLOCK_CTRL_ZERO, 8'hB8); rd(`ADDR_CLOCK_CTRL_ZERO, 8'hF8);
        `CHK("main run", 1'b0, main_osc_run)
        wr(`ADDR_CLOCK_CTRL_ZERO, 8'h98); rd(`ADDR_CLOCK_CTRL_ZERO, 8'h98);
        wr(`ADDR_CLOCK_CTRL_ONE, 8'h01); repeat (2) @(negedge core_clk);
        `CHK("sleep", 1'b1, cpu_sleep)
        pulse_in(0);
        `CHK("sleep", 1'b0, cpu_sleep)
        `CHK("src", clock_mode_pkg::SRC_SUB, cpu_clk_src)
        rd(`ADDR_CLOCK_CTRL_ZERO, 8'hD8);
        wr(`ADDR_CLOCK_CTRL_ZERO, 8'hDC);
        pulse_in(1);
        `CHK("periph off", 1'b1, periph_clk_off & cpu_sleep)
        pulse_in(0);
        `CHK("sleep", 1'b0, cpu_sleep)
        wr(`ADDR_CLOCK_CTRL_ZERO, 8'h5C);
        wr(`ADDR_OSC_MONITOR_CTRL, 8'h02); repeat (2) @(negedge core_clk);
        `CHK("src", clock_mode_pkg::SRC_ONCHIP, cpu_clk_src)
        `CHK("onchip run", 1'b1, onchip_osc_run)
        wr(`ADDR_CLOCK_CTRL_ZERO, 8'h1C); wr(`ADDR_CLOCK_CTRL_ZERO, 8'h5C);
        wr(`ADDR_OSC_MONITOR_CTRL, 8'h00); repeat (2) @(negedge core_clk);
        `CHK("src", clock_mode_pkg::SRC_MAIN, cpu_clk_src)
        wr(`ADDR_WRITE_PROTECT, 8'h02); wr(`ADDR_PROC_MODE_TWO, 8'h02);
        wr(`ADDR_WRITE_PROTECT, 8'h00);
        wr(`ADDR_PLL_CONTROL, 8'h00); rd(`ADDR_PLL_CONTROL, 8'h80);
        wr(`ADDR_CLOCK_CTRL_ZERO, 8'hD8); rd(`ADDR_CLOCK_CTRL_ZERO, 8'h5C);
        wr(`ADDR_CLOCK_CTRL_ONE, 8'h03); rd(`ADDR_CLOCK_CTRL_ONE, 8'h00);
        rd(8'h20, 8'h00);
        do_reset();
        osc_on <= 0;
        c = 0;
        repeat (200) @(negedge core_clk) if (osc_fail_irq === 1'b1) c++;
        `CHK("irq off", 0, c)
        osc_on <= 1; repeat (20) @(posedge core_clk);
        wr(`ADDR_OSC_MONITOR_CTRL, 8'h81);
        osc_on <= 0;
        c = 0;
        while (osc_fail_irq !== 1'b1 && c < 400) begin @(negedge core_clk); c++; end
        `CHK("irq", 1'b1, osc_fail_irq)
        do_reset();
        osc_on <= 1; repeat (20) @(posedge core_clk);
        wr(`ADDR_OSC_MONITOR_CTRL, 8'h01);
        osc_on <= 0;
        repeat (300) @(negedge core_clk);
        `CHK("halt", 2'b11, {osc_fail_reset, cpu_sleep})
        osc_on <= 1;
        repeat (50) @(negedge core_clk);
        `CHK("halt held", 1'b1, osc_fail_reset)
        do_reset();
        @(negedge core_clk);
        `CHK("halt cleared", 1'b0, osc_fail_reset)
        give_verdict();
    end
endmodule // clock_mode_ctrl_bench
